/* core/psf_datapath.v */
// Symbol-pair data path: scrambler, descrambler, repeat filter, data
// stream generator and the seven path multiplexers, with an AXI4-Lite
// register slave. Framer, buffer, codec and state machines are outside
// and meet this block through plain ports, all sampled on i_ref_clk.
// Contract
// [R1] Enabled scrambler XORs each transmit bit with an x^11+x^9 generator.
// [R2] Descrambler XORs received bits with an identical generator.
// [R3] Synchroniser works only during resync request; otherwise free run.
// [R4] On pattern match output deduced data; load generator data^input.
// [R5] No match: output input^generator; generator runs on own feedback.
// [R6] Generator feedback is bit 11 XOR bit 9.
// [R7] Quiet, idle, halt and master patterns map to fixed hypotheses.
// [R8] Scrambling enabled when cipher pin or scramble_on bit is high.
// [R9] Repeat filter turns invalid line states after remote loop to Idle.
// [R10] Corrupted frame: four Halts, then Idle until next JK pair; code sends two Halts (PSF_HALT_PAIRS).
// [R11] Idle before ending delimiter rewrites previous pair to Idle.
// [R12] Stream generator picks request, maintenance, filter or tx pair.
// [R13] Stream generator registers every cycle for the eraser delay.
// [R14] Framer takes transmit-output latch under framer loopback or test.
// [R15] Scrambler loopback feeds descrambler output to scrambler input.
// [R16] Decoder takes transmit-output latch under decoder loopback or test.
// [R17] Bypass conditions route transmit input to receive output.
// [R18] Remote loop alone, or self test, puts decoder output on transmit.
// [R19] Scrub conditions drive Idle pairs to receive-output latch.
// [R20] Self test feeds test generator data to the transmit-output latch.
// [R21] Disabled cipher passes data unchanged with same latency.
`include "psf_defines.vh"

module psf_datapath (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_srst,
	// AXI4-Lite register slave
	input wire [`PSF_ADDR_W-1:0] i_awaddr,
	input wire i_awvalid,
	output reg o_awready_q,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	input wire i_wvalid,
	output reg o_wready_q,
	output reg [1:0] o_bresp_q,
	output reg o_bvalid_q,
	input wire i_bready,
	input wire [`PSF_ADDR_W-1:0] i_araddr,
	input wire i_arvalid,
	output reg o_arready_q,
	output reg [31:0] o_rdata_q,
	output reg [1:0] o_rresp_q,
	output reg o_rvalid_q,
	input wire i_rready,
	// Line side pairs
	input wire [9:0] i_line_rx_pair,
	output reg [9:0] o_line_tx_pair_q,
	// Receive path
	output reg [9:0] o_framer_in_q,
	input wire [9:0] i_eb_out,
	output reg [9:0] o_decoder_in_q,
	input wire [9:0] i_decoder_out,
	output reg [9:0] o_rx_pair_q,
	// Transmit path
	input wire [9:0] i_tx_pair_in,
	output reg [9:0] o_stream_bus_q,
	input wire [9:0] i_encoder_out,
	// Control from neighbouring blocks
	input wire i_resync_request,
	input wire i_cipher_pin,
	input wire i_service_state,
	input wire [2:0] i_pci_state,
	input wire i_line_state_request_valid,
	input wire [9:0] i_line_state_request,
	input wire i_self_test_run,
	input wire [9:0] i_self_test_data
);

	// ****************************************************************
	// Register file and AXI4-Lite slave
	// ****************************************************************
	localparam RF_OUT = 2'h0;
	localparam RF_FRAME = 2'h1;
	localparam RF_HALT = 2'h2;
	localparam RF_HUNT = 2'h3;
	localparam FC_PASS = 2'h0;
	localparam FC_IDLE = 2'h1;
	localparam FC_HALT = 2'h2;

	reg [4:0] ctrl_one_q;
	reg [10:0] ctrl_two_q;
	reg [1:0] ctrl_three_q;
	reg bypass_hold_q;
	reg [`PSF_ADDR_W-1:0] aw_addr_q;
	reg aw_got_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg w_got_q;
	reg [1:0] rf_state_q;
	reg [1:0] rf_state_d;
	reg [1:0] halt_cnt_q;
	reg [1:0] halt_cnt_d;
	reg [1:0] filter_control;
	reg fragment;
	reg [10:0] scr_gen_q;
	reg [10:0] dsc_gen_q;
	reg [10:0] dsc_hist_q;
	reg [10:0] dsc_hyp_q;
	reg [9:0] rx_in_latch_q;
	reg [9:0] tx_in_latch_q;
	reg [9:0] tx_out_latch_q;
	reg [9:0] remote_q;
	reg [9:0] stream_q;
	reg [9:0] stream_d;
	reg [31:0] rd_word;
	reg rd_hit;
	wire cipher_on;
	wire [20:0] scr_res;
	wire [42:0] dsc_res;
	wire [9:0] scr_in;
	wire bypass_sel;
	wire scrub_sel;
	wire remote_sel;
	wire [9:0] bypass_out;

	assign cipher_on = i_cipher_pin | ctrl_three_q[`PSF_C3_SCRAMBLE_ON]; // [R8]

	// Reads are decoded here so the answer is registered on the take.
	always @*
	begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		case (i_araddr)
			`PSF_OFS_CTRL_ONE: rd_word = {27'h0, ctrl_one_q};
			`PSF_OFS_CTRL_TWO: rd_word = {21'h0, ctrl_two_q};
			`PSF_OFS_CTRL_THREE: rd_word = {30'h0, ctrl_three_q};
			`PSF_OFS_STATUS: rd_word = {26'h0, rf_state_q, scrub_sel,
				bypass_sel, i_resync_request, cipher_on};
			default: rd_hit = 1'b0;
		endcase
	end

	always @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_awready_q <= 1'b1;
			o_wready_q <= 1'b1;
			o_bvalid_q <= 1'b0;
			o_bresp_q <= `PSF_RESP_OKAY;
			o_arready_q <= 1'b1;
			o_rvalid_q <= 1'b0;
			o_rresp_q <= `PSF_RESP_OKAY;
			o_rdata_q <= 32'h0000_0000;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= {`PSF_ADDR_W{1'b0}};
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			ctrl_one_q <= `PSF_RST_CTRL_ONE;
			ctrl_two_q <= `PSF_RST_CTRL_TWO;
			ctrl_three_q <= `PSF_RST_CTRL_THREE;
			bypass_hold_q <= 1'b1;
		end
		else
		begin
			if (o_awready_q & i_awvalid)
			begin
				aw_addr_q <= i_awaddr;
				aw_got_q <= 1'b1;
				o_awready_q <= 1'b0;
			end
			if (o_wready_q & i_wvalid)
			begin
				w_data_q <= i_wdata;
				w_strb_q <= i_wstrb;
				w_got_q <= 1'b1;
				o_wready_q <= 1'b0;
			end
			if (aw_got_q & w_got_q & ~o_bvalid_q)
			begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				o_bvalid_q <= 1'b1;
				o_bresp_q <= `PSF_RESP_OKAY;
				case (aw_addr_q)
					`PSF_OFS_CTRL_ONE:
						if (w_strb_q[0])
							ctrl_one_q <= w_data_q[4:0];
					`PSF_OFS_CTRL_TWO:
					begin
						if (w_strb_q[0])
							ctrl_two_q[7:0] <= w_data_q[7:0];
						if (w_strb_q[1])
							ctrl_two_q[10:8] <= w_data_q[10:8];
						// The first write to PSF_OFS_CTRL_TWO releases the reset bypass.
						bypass_hold_q <= 1'b0;
					end
					`PSF_OFS_CTRL_THREE:
						if (w_strb_q[0])
							ctrl_three_q <= w_data_q[1:0];
					`PSF_OFS_STATUS: o_bresp_q <= `PSF_RESP_OKAY;
					default: o_bresp_q <= `PSF_RESP_SLVERR;
				endcase
			end
			if (o_bvalid_q & i_bready)
			begin
				o_bvalid_q <= 1'b0;
				o_awready_q <= 1'b1;
				o_wready_q <= 1'b1;
			end
			if (o_arready_q & i_arvalid)
			begin
				o_arready_q <= 1'b0;
				o_rvalid_q <= 1'b1;
				o_rdata_q <= rd_word;
				o_rresp_q <= rd_hit ? `PSF_RESP_OKAY : `PSF_RESP_SLVERR;
			end
			if (o_rvalid_q & i_rready)
			begin
				o_rvalid_q <= 1'b0;
				o_arready_q <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Stream cipher: ten serial steps per pair, bit 9 first
	// ****************************************************************
	function [20:0] scr_pair;
		input [9:0] d;
		input [10:0] s;
		integer k;
		reg [10:0] g_reg;
		reg [9:0] o;
		reg fb;
		begin
			g_reg = s;
			o = 10'h000;
			for (k = 9; k >= 0; k = k - 1)
			begin
				fb = g_reg[10] ^ g_reg[8]; // [R6]
				o[k] = d[k] ^ fb; // [R1]
				g_reg = {g_reg[9:0], fb};
			end
			scr_pair = {g_reg, o};
		end
	endfunction

	function [42:0] dsc_pair;
		input [9:0] d;
		input [10:0] s;
		input [10:0] sh;
		input [10:0] hh;
		input sync;
		integer k;
		reg [10:0] g_reg;
		reg [10:0] s_hist;
		reg [10:0] h_hist;
		reg [9:0] o;
		reg fb;
		reg hyp;
		reg hit;
		reg ded;
		begin
			g_reg = s;
			s_hist = sh;
			h_hist = hh;
			o = 10'h000;
			for (k = 9; k >= 0; k = k - 1)
			begin
				fb = g_reg[10] ^ g_reg[8]; // [R6]
				hyp = d[k] ^ s_hist[10] ^ s_hist[8];
				h_hist = {h_hist[9:0], hyp};
				hit = 1'b1;
				ded = 1'b0;
				case (h_hist) // [R7]
					`PSF_H_QLS: ded = |(`PSF_D_QLS & 11'h001);
					`PSF_H_ILS: ded = |(`PSF_D_ILS & 11'h001);
					`PSF_H_HLS: ded = |(`PSF_D_HLS & 11'h001);
					`PSF_H_MLS: ded = |(`PSF_D_MLS & 11'h001);
					default: hit = 1'b0;
				endcase
				if (sync & hit)
				begin
					o[k] = ded; // [R4]
					g_reg = {g_reg[9:0], ded ^ d[k]}; // [R4]
				end
				else
				begin
					o[k] = d[k] ^ fb; // [R2] [R5]
					g_reg = {g_reg[9:0], fb}; // [R3] [R5]
				end
				s_hist = {s_hist[9:0], d[k]};
			end
			dsc_pair = {g_reg, s_hist, h_hist, o};
		end
	endfunction

	// Scrambler loopback returns receive data to the transmit cipher.
	assign scr_in = ~ctrl_three_q[`PSF_C3_SCRAMBLER_LB] ? tx_out_latch_q :
		cipher_on ? dsc_res[9:0] : i_line_rx_pair; // [R15] [R21]
	assign scr_res = scr_pair(scr_in, scr_gen_q);
	assign dsc_res = dsc_pair(i_line_rx_pair, dsc_gen_q, dsc_hist_q,
		dsc_hyp_q, i_resync_request); // [R3]

	// Generators keep running while disabled so that turning the cipher on
	// needs no restart; only the data bypasses them.
	always @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			scr_gen_q <= 11'h7ff;
			dsc_gen_q <= 11'h000;
			dsc_hist_q <= 11'h000;
			dsc_hyp_q <= 11'h000;
			o_line_tx_pair_q <= 10'h000;
			rx_in_latch_q <= 10'h000;
		end
		else
		begin
			scr_gen_q <= scr_res[20:10];
			dsc_gen_q <= dsc_res[42:32];
			dsc_hist_q <= dsc_res[31:21];
			dsc_hyp_q <= dsc_res[20:10];
			o_line_tx_pair_q <= cipher_on ? scr_res[9:0] : scr_in; // [R21]
			rx_in_latch_q <= cipher_on ? dsc_res[9:0] :
				i_line_rx_pair; // [R21] [R15]
		end
	end

	// ****************************************************************
	// Receive path multiplexers
	// ****************************************************************
	assign bypass_sel = bypass_hold_q |
		(ctrl_one_q[`PSF_C1_BYPASS_REQ] & i_service_state) |
		ctrl_two_q[`PSF_C2_CONC_BYPASS] |
		(i_pci_state == `PSF_PCI_DETACHED) |
		(i_pci_state == `PSF_PCI_JOIN_CLEAN) |
		(i_pci_state == `PSF_PCI_LEAVE_CLEAN); // [R17]
	assign scrub_sel = (ctrl_one_q[`PSF_C1_SCRUB_REQ] & i_service_state) |
		ctrl_two_q[`PSF_C2_CONC_BYPASS] |
		(i_pci_state == `PSF_PCI_JOIN_CLEAN) |
		(i_pci_state == `PSF_PCI_LEAVE_CLEAN); // [R19]
	assign bypass_out = bypass_sel ? tx_in_latch_q : i_decoder_out; // [R17]
	assign remote_sel = (ctrl_one_q[`PSF_C1_REMOTE_LOOP] &
		~ctrl_one_q[`PSF_C1_FRAMER_LB] & ~ctrl_one_q[`PSF_C1_DECODER_LB] &
		~ctrl_three_q[`PSF_C3_SCRAMBLER_LB]) | i_self_test_run; // [R18]

	always @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_framer_in_q <= 10'h000;
			o_decoder_in_q <= 10'h000;
			o_rx_pair_q <= `PSF_IDLE_PAIR;
			tx_in_latch_q <= 10'h000;
			tx_out_latch_q <= 10'h000;
			remote_q <= 10'h000;
		end
		else
		begin
			o_framer_in_q <= (ctrl_one_q[`PSF_C1_FRAMER_LB] |
				i_self_test_run) ? tx_out_latch_q : rx_in_latch_q; // [R14]
			o_decoder_in_q <= (ctrl_one_q[`PSF_C1_DECODER_LB] |
				i_self_test_run) ? tx_out_latch_q : i_eb_out; // [R16]
			o_rx_pair_q <= scrub_sel ? `PSF_IDLE_PAIR : bypass_out; // [R19]
			tx_in_latch_q <= i_tx_pair_in;
			tx_out_latch_q <= i_self_test_run ? i_self_test_data :
				i_encoder_out; // [R20]
			remote_q <= remote_sel ? i_decoder_out : tx_in_latch_q; // [R18]
		end
	end

	// ****************************************************************
	// Repeat filter on the pair leaving the remote loopback latch
	// ****************************************************************
	wire [4:0] sym_a;
	wire [4:0] sym_b;
	wire has_v;
	wire has_bad;
	wire has_i;
	wire has_t;
	wire is_jk;

	assign sym_a = remote_q[9:5];
	assign sym_b = remote_q[4:0];
	assign has_v = (sym_a == `PSF_SYM_V) | (sym_b == `PSF_SYM_V);
	assign has_bad = has_v | (sym_a == `PSF_SYM_H) | (sym_b == `PSF_SYM_H) |
		(sym_a == `PSF_SYM_Q) | (sym_b == `PSF_SYM_Q);
	assign has_i = (sym_a == `PSF_SYM_I) |
		((sym_b == `PSF_SYM_I) & (sym_a != `PSF_SYM_T));
	assign has_t = (sym_a == `PSF_SYM_T) | (sym_b == `PSF_SYM_T);
	assign is_jk = (sym_a == `PSF_SYM_J) & (sym_b == `PSF_SYM_K);

	always @*
	begin
		rf_state_d = rf_state_q;
		halt_cnt_d = halt_cnt_q;
		filter_control = FC_PASS;
		fragment = 1'b0;
		case (rf_state_q)
			RF_OUT:
				if (is_jk)
					rf_state_d = RF_FRAME;
				else if (has_v)
					filter_control = FC_IDLE; // [R9]
			RF_FRAME:
				if (is_jk)
					rf_state_d = RF_FRAME;
				else if (has_bad)
				begin
					filter_control = FC_HALT; // [R10]
					halt_cnt_d = `PSF_HALT_PAIRS - 2'h1;
					rf_state_d = RF_HALT;
				end
				else if (has_i)
				begin
					fragment = 1'b1; // [R11]
					rf_state_d = RF_OUT;
				end
				else if (has_t)
					rf_state_d = RF_OUT;
			RF_HALT:
			begin
				filter_control = FC_HALT; // [R10]
				halt_cnt_d = halt_cnt_q - 2'h1;
				if (halt_cnt_q == 2'h1)
					rf_state_d = RF_HUNT;
			end
			RF_HUNT:
				if (is_jk)
					rf_state_d = RF_FRAME;
				else
					filter_control = FC_IDLE; // [R10]
			default: rf_state_d = RF_OUT;
		endcase
	end

	// ****************************************************************
	// Data stream generator and fragment eraser
	// ****************************************************************
	always @*
	begin
		if (i_service_state)
			stream_d = ctrl_two_q[9:0]; // [R12]
		else if (i_line_state_request_valid)
			stream_d = i_line_state_request; // [R12]
		else if (filter_control == FC_HALT)
			stream_d = `PSF_HALT_PAIR; // [R12]
		else if (filter_control == FC_IDLE)
			stream_d = `PSF_IDLE_PAIR;
		else
			stream_d = remote_q; // [R12]
	end

	// The stage in stream_q is what lets a fragment seen now rewrite the
	// pair that came just before it.
	always @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			rf_state_q <= RF_OUT;
			halt_cnt_q <= 2'h0;
			stream_q <= `PSF_IDLE_PAIR;
			o_stream_bus_q <= `PSF_IDLE_PAIR;
		end
		else
		begin
			rf_state_q <= rf_state_d;
			halt_cnt_q <= halt_cnt_d;
			stream_q <= stream_d; // [R13]
			o_stream_bus_q <= fragment ? `PSF_IDLE_PAIR : stream_q; // [R11]
		end
	end

endmodule

/* core/psf_defines.vh */
// Constants for the symbol-pair scrambler, repeat filter and path muxes.
// Assumes decoded 5-bit symbols, pairs carried as {first, second}.
`ifndef PSF_DEFINES_VH
`define PSF_DEFINES_VH

// ****************************************************************
// Register map (byte addresses) and bus answers
// ****************************************************************
`define PSF_ADDR_W 8
`define PSF_OFS_CTRL_ONE 8'h00
`define PSF_OFS_CTRL_TWO 8'h04
`define PSF_OFS_CTRL_THREE 8'h08
`define PSF_OFS_STATUS 8'h0c
`define PSF_RESP_OKAY 2'h0
`define PSF_RESP_SLVERR 2'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define PSF_C1_FRAMER_LB 0
`define PSF_C1_DECODER_LB 1
`define PSF_C1_BYPASS_REQ 2
`define PSF_C1_SCRUB_REQ 3
`define PSF_C1_REMOTE_LOOP 4
`define PSF_C2_CONC_BYPASS 10
`define PSF_C3_SCRAMBLE_ON 0
`define PSF_C3_SCRAMBLER_LB 1

// ****************************************************************
// Reset values
// ****************************************************************
`define PSF_RST_CTRL_ONE 5'h00
`define PSF_RST_CTRL_TWO 11'h000
`define PSF_RST_CTRL_THREE 2'h0

// ****************************************************************
// Decoded symbols and pairs
// ****************************************************************
`define PSF_SYM_Q 5'h10
`define PSF_SYM_I 5'h17
`define PSF_SYM_H 5'h14
`define PSF_SYM_J 5'h1c
`define PSF_SYM_K 5'h13
`define PSF_SYM_T 5'h1d
`define PSF_SYM_V 5'h18
`define PSF_IDLE_PAIR 10'h2f7
`define PSF_HALT_PAIR 10'h294

// ****************************************************************
// Line-state hypothesis patterns and deduced data, newest bit in 0
// ****************************************************************
`define PSF_H_QLS 11'h000
`define PSF_H_ILS 11'h7ff
`define PSF_H_HLS 11'h39c
`define PSF_H_MLS 11'h380
`define PSF_D_QLS 11'h000
`define PSF_D_ILS 11'h7ff
`define PSF_D_HLS 11'h108
`define PSF_D_MLS 11'h080

// ****************************************************************
// Insertion controller states and timing
// ****************************************************************
`define PSF_PCI_DETACHED 3'h0
`define PSF_PCI_JOIN_CLEAN 3'h1
`define PSF_PCI_LEAVE_CLEAN 3'h2
`define PSF_HALT_PAIRS 2'h2

`endif

/* bench/psf_datapath_monitor.sv */
// Checker for the symbol-pair data path, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`include "psf_defines.vh"

module psf_datapath_monitor (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Register bus
	input wire logic i_awvalid,
	input wire logic o_awready_q,
	input wire logic i_wvalid,
	input wire logic o_wready_q,
	input wire logic o_bvalid_q,
	input wire logic i_arvalid,
	input wire logic o_arready_q,
	input wire logic o_rvalid_q,
	input wire logic [31:0] o_rdata_q,
	input wire logic i_rready,
	// Data path
	input wire logic [9:0] i_tx_pair_in,
	input wire logic [9:0] o_rx_pair_q,
	input wire logic [9:0] o_stream_bus_q,
	input wire logic [9:0] o_framer_in_q,
	input wire logic [9:0] o_decoder_in_q,
	input wire logic i_service_state,
	input wire logic [2:0] i_pci_state,
	input wire logic i_line_state_request_valid,
	input wire logic [9:0] i_line_state_request,
	input wire logic i_self_test_run,
	input wire logic [9:0] i_self_test_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);

	// ****************************************************************
	// Sequences and assertions
	// ****************************************************************
	sequence s_write_taken;
		i_awvalid && o_awready_q && i_wvalid && o_wready_q;
	endsequence
	sequence s_write_done;
		!o_bvalid_q ##1 o_bvalid_q;
	endsequence

	a_reset_values: assert property ($fell(i_srst) |->
		o_rx_pair_q == `PSF_IDLE_PAIR && o_stream_bus_q == `PSF_IDLE_PAIR
		&& o_awready_q && o_arready_q && !o_bvalid_q && !o_rvalid_q)
		else $error("outputs not at reset values");
	a_read_answer: assert property (i_arvalid && o_arready_q |=>
		o_rvalid_q && !o_arready_q)
		else $error("read answer not one cycle after address");
	a_write_answer: assert property (s_write_taken |=> s_write_done)
		else $error("write answer not two cycles after take");
	a_rdata_stands: assert property (o_rvalid_q && !i_rready |=>
		o_rvalid_q && $stable(o_rdata_q))
		else $error("read data dropped before handshake");
	a_busy_refuse: assert property ((o_bvalid_q |-> !o_awready_q &&
		!o_wready_q) and (o_rvalid_q |-> !o_arready_q))
		else $error("bus accepted a request while busy");
	a_scrub_idle: assert property (
		(i_pci_state == `PSF_PCI_JOIN_CLEAN ||
		i_pci_state == `PSF_PCI_LEAVE_CLEAN)[*3]
		|-> o_rx_pair_q == `PSF_IDLE_PAIR)
		else $error("receive output not idle while scrubbing");
	a_detach_bypass: assert property (
		(i_pci_state == `PSF_PCI_DETACHED && $stable(i_tx_pair_in))[*3]
		|-> o_rx_pair_q == i_tx_pair_in || o_rx_pair_q == `PSF_IDLE_PAIR)
		else $error("detached port not bypassed");
	a_state_request: assert property (
		(i_line_state_request_valid && !i_service_state &&
		$stable(i_line_state_request))[*3]
		|-> o_stream_bus_q == i_line_state_request)
		else $error("stream bus ignores line state request");
	a_self_test_loop: assert property (
		(i_self_test_run && $stable(i_self_test_data))[*4]
		|-> o_framer_in_q == i_self_test_data &&
		o_decoder_in_q == i_self_test_data)
		else $error("self test data not looped to receive path");
endmodule

bind psf_datapath psf_datapath_monitor psf_datapath_monitor_inst (.*);

/* bench/psf_far_phy.sv */
// Far-end line model: a receiver chip feeding the line receive pins.
// Assumes the bench picks between a fixed pattern and a cable loop.
module psf_far_phy (
	// Clock
	input wire logic i_ref_clk,
	// Control from the bench
	input wire logic i_loop_en,
	input wire logic [9:0] i_pattern,
	// Line pins
	input wire logic [9:0] i_line_tx_pair,
	output logic [9:0] o_line_rx_pair = 10'h000
);
	timeunit 1ns;
	timeprecision 1ps;

	// The loop adds one cycle, as a real cable and receiver would.
	always @(posedge i_ref_clk)
		o_line_rx_pair <= i_loop_en ? i_line_tx_pair : i_pattern;
endmodule

/* bench/psf_datapath_tb.sv */
// Self-checking bench for the symbol-pair data path.
// Assumes the far-end model on the line pins and the bound checker.
`include "psf_defines.vh"

module psf_datapath_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] TXI = 10'h0a5, DEC = 10'h0e7, ENC = 10'h123;
	localparam logic [9:0] FAR = 10'h2a5, EBO = 10'h0f0, TST = 10'h35a;
	localparam logic [9:0] D1 = 10'h022, D2 = 10'h064, JK = 10'h393;
	localparam logic [9:0] VV = 10'h318, TT = 10'h3bd, QQ = 10'h210;
	localparam logic [9:0] MNT = 10'h0c6;
	logic i_ref_clk = 1'b0, i_srst = 1'b1;
	logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic i_arvalid = 1'b0, i_rready = 1'b0;
	logic [31:0] i_wdata = 32'h0;
	logic [3:0] i_wstrb = 4'hf;
	logic o_awready_q, o_wready_q, o_bvalid_q, o_arready_q, o_rvalid_q;
	logic [1:0] o_bresp_q, o_rresp_q;
	logic [31:0] o_rdata_q;
	wire logic [9:0] i_line_rx_pair;
	logic [9:0] o_line_tx_pair_q, o_framer_in_q, o_decoder_in_q;
	logic [9:0] o_rx_pair_q, o_stream_bus_q;
	logic [9:0] i_eb_out = EBO, i_decoder_out = DEC, i_tx_pair_in = TXI;
	logic [9:0] i_encoder_out = ENC, i_self_test_data = TST;
	logic [9:0] i_line_state_request = QQ;
	logic i_resync_request = 1'b0, i_cipher_pin = 1'b0;
	logic i_service_state = 1'b0, i_line_state_request_valid = 1'b0;
	logic i_self_test_run = 1'b0, loop_en = 1'b0, watch = 1'b0;
	logic [2:0] i_pci_state = 3'h3;
	logic [1:0] last_resp;
	logic [31:0] last_rdata;
	int miscompares = 0, num_checks = 0, n_halt = 0, n_d1 = 0, n_d2 = 0;

	psf_datapath psf_datapath_inst (.*);
	psf_far_phy psf_far_phy_inst (.i_ref_clk(i_ref_clk),
		.i_loop_en(loop_en), .i_pattern(FAR),
		.i_line_tx_pair(o_line_tx_pair_q), .o_line_rx_pair(i_line_rx_pair));

	always #20 i_ref_clk = ~i_ref_clk;

	always @(posedge i_ref_clk)
		if (!watch)
		begin
			n_halt = 0;
			n_d1 = 0;
			n_d2 = 0;
		end
		else
		begin
			n_halt += int'(o_stream_bus_q === `PSF_HALT_PAIR);
			n_d1 += int'(o_stream_bus_q === D1);
			n_d2 += int'(o_stream_bus_q === D2);
		end

	// ****************************************************************
	// Bus and compare tasks
	// ****************************************************************
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic got;
		n = 0;
		got = 1'b0;
		@(posedge i_ref_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		while (!got && n < 100)
		begin
			@(posedge i_ref_clk);
			n++;
			if (i_awvalid && o_awready_q)
				i_awvalid <= 1'b0;
			if (i_wvalid && o_wready_q)
				i_wvalid <= 1'b0;
			got = o_bvalid_q && i_bready;
		end
		last_resp = o_bresp_q;
		i_bready <= 1'b0;
		if (!got)
			miscompares++;
	endtask

	// Ready is raised late on purpose so the answer must stand a cycle.
	task automatic rd(input logic [7:0] a);
		int n;
		logic got;
		n = 0;
		got = 1'b0;
		@(posedge i_ref_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		while (!got && n < 100)
		begin
			@(posedge i_ref_clk);
			n++;
			if (i_arvalid && o_arready_q)
				i_arvalid <= 1'b0;
			got = o_rvalid_q && i_rready;
			if (o_rvalid_q && !i_rready)
				i_rready <= 1'b1;
		end
		last_rdata = o_rdata_q;
		last_resp = o_rresp_q;
		i_rready <= 1'b0;
		if (!got)
			miscompares++;
	endtask

	task automatic settle;
		repeat (4) @(posedge i_ref_clk);
	endtask

	task automatic feed(input logic [9:0] p, input int k);
		repeat (k)
		begin
			@(posedge i_ref_clk);
			i_decoder_out <= p;
		end
	endtask

	task automatic arm;
		watch <= 1'b0;
		@(posedge i_ref_clk);
		watch <= 1'b1;
	endtask

	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		wr(a, d);
		check(last_resp, `PSF_RESP_OKAY);
		rd(a);
		check({last_resp, last_rdata}, {2'h0, e});
	endtask

	task automatic chk_rx(input logic [2:0] p, input logic s,
		input logic [4:0] c1, input logic [10:0] c2, input logic [9:0] e);
		i_pci_state <= p;
		i_service_state <= s;
		wr(`PSF_OFS_CTRL_ONE, {27'h0, c1});
		wr(`PSF_OFS_CTRL_TWO, {21'h0, c2});
		settle();
		check(o_rx_pair_q, e);
	endtask

	task automatic chk_lb(input logic [4:0] c1, input logic [1:0] c3,
		input logic st, input logic [29:0] e);
		i_self_test_run <= st;
		wr(`PSF_OFS_CTRL_ONE, {27'h0, c1});
		wr(`PSF_OFS_CTRL_THREE, {30'h0, c3});
		settle();
		check({o_framer_in_q, o_decoder_in_q, o_line_tx_pair_q}, e);
	endtask

	task automatic chk_cipher(input logic p, input logic b);
		int diff;
		diff = 0;
		i_cipher_pin <= p;
		wr(`PSF_OFS_CTRL_THREE, {31'h0, b});
		rd(`PSF_OFS_STATUS);
		check(last_rdata[0], p | b);
		repeat (16)
		begin
			@(posedge i_ref_clk);
			diff += int'(o_line_tx_pair_q !== i_encoder_out);
		end
		check(diff != 0, p | b);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		repeat (6) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		settle();
		check(o_rx_pair_q, TXI);
		wr_rd(`PSF_OFS_CTRL_ONE, 32'hffffffff, 32'h1f);
		wr_rd(`PSF_OFS_CTRL_TWO, 32'hffffffff, 32'h7ff);
		wr_rd(`PSF_OFS_CTRL_THREE, 32'hffffffff, 32'h3);
		wr(8'h20, 32'h1);
		check(last_resp, `PSF_RESP_SLVERR);
		rd(8'h20);
		check({last_resp, last_rdata}, {`PSF_RESP_SLVERR, 32'h0});
		wr(`PSF_OFS_STATUS, 32'h0);
		check(last_resp, `PSF_RESP_OKAY);
		wr_rd(`PSF_OFS_CTRL_THREE, 32'h0, 32'h0);
		$display("test registers done");
		chk_rx(3'h3, 1'b0, 5'h00, 11'h000, DEC);
		chk_rx(3'h0, 1'b0, 5'h00, 11'h000, TXI);
		chk_rx(3'h1, 1'b0, 5'h00, 11'h000, `PSF_IDLE_PAIR);
		chk_rx(3'h2, 1'b0, 5'h00, 11'h000, `PSF_IDLE_PAIR);
		chk_rx(3'h3, 1'b1, 5'h04, 11'h000, TXI);
		chk_rx(3'h3, 1'b0, 5'h04, 11'h000, DEC);
		chk_rx(3'h3, 1'b1, 5'h08, 11'h000, `PSF_IDLE_PAIR);
		chk_rx(3'h3, 1'b0, 5'h08, 11'h000, DEC);
		chk_rx(3'h3, 1'b0, 5'h00, 11'h400, `PSF_IDLE_PAIR);
		chk_rx(3'h3, 1'b0, 5'h00, 11'h000, DEC);
		$display("test receive muxes done");
		chk_lb(5'h00, 2'h0, 1'b0, {FAR, EBO, ENC});
		chk_lb(5'h01, 2'h0, 1'b0, {ENC, EBO, ENC});
		chk_lb(5'h02, 2'h0, 1'b0, {FAR, ENC, ENC});
		chk_lb(5'h00, 2'h2, 1'b0, {FAR, EBO, FAR});
		chk_lb(5'h00, 2'h0, 1'b1, {TST, TST, TST});
		loop_en <= 1'b1;
		chk_lb(5'h00, 2'h0, 1'b0, {ENC, EBO, ENC});
		loop_en <= 1'b0;
		$display("test loopbacks done");
		chk_cipher(1'b0, 1'b0);
		chk_cipher(1'b1, 1'b0);
		chk_cipher(1'b0, 1'b1);
		chk_cipher(1'b1, 1'b1);
		chk_cipher(1'b0, 1'b0);
		loop_en <= 1'b1;
		i_cipher_pin <= 1'b1;
		i_encoder_out <= 10'h3ff;
		i_resync_request <= 1'b1;
		settle();
		settle();
		i_resync_request <= 1'b0;
		i_encoder_out <= ENC;
		settle();
		settle();
		check(o_framer_in_q, ENC);
		i_cipher_pin <= 1'b0;
		loop_en <= 1'b0;
		$display("test cipher done");
		chk_lb(5'h00, 2'h0, 1'b0, {FAR, EBO, ENC});
		check(o_stream_bus_q, TXI);
		chk_lb(5'h11, 2'h0, 1'b0, {ENC, EBO, ENC});
		check(o_stream_bus_q, TXI);
		chk_lb(5'h10, 2'h0, 1'b0, {FAR, EBO, ENC});
		check(o_stream_bus_q, DEC);
		i_line_state_request_valid <= 1'b1;
		settle();
		check(o_stream_bus_q, QQ);
		i_service_state <= 1'b1;
		wr(`PSF_OFS_CTRL_TWO, {22'h0, MNT});
		settle();
		check(o_stream_bus_q, MNT);
		i_service_state <= 1'b0;
		i_line_state_request_valid <= 1'b0;
		$display("test stream sources done");
		arm();
		feed(JK, 1);
		feed(D1, 2);
		feed(VV, 1);
		feed(D1, 8);
		check(n_halt, 2);
		check(o_stream_bus_q, `PSF_IDLE_PAIR);
		feed(JK, 1);
		feed(D1, 5);
		check(o_stream_bus_q, D1);
		feed(TT, 1);
		feed(VV, 5);
		check(o_stream_bus_q, `PSF_IDLE_PAIR);
		arm();
		feed(JK, 1);
		feed(D1, 1);
		feed(D2, 1);
		feed(`PSF_IDLE_PAIR, 5);
		check(n_d2, 0);
		check(n_d1 != 0, 1);
		$display("test repeat filter done");
		give_verdict();
	end

	// The tests take a few hundred cycles; this allows ample margin.
	initial
	begin
		#800000;
		miscompares++;
		give_verdict();
	end
endmodule
